//--- fls_top.sv
// Fault limit supervisor: management bus slave, limit registers,
// temperature and phase current compares, alert and retry control.
// Assumes scl/sda arrive from pins; measurements arrive on clk.
//
// Functional notes
// - Per-phase under-current threshold, either phase faults
// - Combined under-current limit is twice programmed
// - Word over-temperature fault threshold in Linear
// - Byte over-temperature reaction setting
// - Any reaction mode pulls alert, sets status
// - Disable-and-retry turns output off immediately
// - Retry field sets number of restarts
// - Zero retries: stay off until cleared
// - All ones retries forever until disabled
// - Retry spacing is (code+1) times 35 ms
// - Word over-temperature warning threshold in Linear
// - Word under-temperature warning threshold in Linear
`timescale 1ns/10ps
module fls_top #(
  parameter logic [6:0]  DEV_ADDR = fls_pkg::BUS_ADDR,
  parameter logic [31:0] STEP_CYC = fls_pkg::RETRY_STEP_CYC
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [15:0]         temp_lin,
  input  wire logic [15:0]         iph0_lin,
  input  wire logic [15:0]         iph1_lin,
  input  wire logic                on_req,
  input  wire logic                clear_faults,
  output logic                     out_en,
  output fls_pkg::fls_status_t     status,
  output logic                     alert_out_n,
  output logic [15:0]              uc_combined_lim
);

  // ----------------------------------------------------------------
  // Linear to signed fixed point, 16 fraction bits
  // ----------------------------------------------------------------
  function automatic logic signed [47:0] lin_fx(input logic [15:0] w);
    logic signed [47:0] m;
    logic signed [5:0]  ex;
    logic        [5:0]  neg;
    m   = {{37{w[10]}}, w[10:0]} <<< 16;
    ex  = {w[15], w[15:11]};
    neg = 6'h0 - ex;
    if (ex < 0) begin
      lin_fx = m >>> neg;
    end else begin
      lin_fx = m <<< ex;
    end
  endfunction : lin_fx

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_ff, sda_sync_ff;  // Two-stage synchronisers
  logic       scl_d_ff, sda_d_ff;        // Previous settled level

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end

  wire scl_s    = scl_sync_ff[1];            // Settled clock level
  wire sda_s    = sda_sync_ff[1];            // Settled data level
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c  = scl_s & scl_d_ff & ~sda_s & sda_d_ff;  // Data falls, clock high
  wire stop_c   = scl_s & scl_d_ff & sda_s & ~sda_d_ff;  // Data rises, clock high

  // ----------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------
  logic [15:0]        uc_peak_thr_ff;        // Per-phase under-current
  logic [15:0]        ot_fault_thr_ff;       // Over-temp fault
  fls_pkg::fls_resp_t ot_react_ff;           // Over-temp reaction
  logic [15:0]        ot_warn_thr_ff;        // Over-temp warning
  logic [15:0]        ut_warn_thr_ff;        // Under-temp warning

  // ----------------------------------------------------------------
  // Bus engine state
  // ----------------------------------------------------------------
  fls_pkg::fls_bstate_t bs_ff;               // Bit phase
  logic [3:0]           cnt_ff;              // Bit count in byte
  logic [7:0]           sh_ff;               // Receive shift register
  logic [7:0]           tx_ff;               // Byte being sent
  logic [1:0]           nbyte_ff;            // Bytes received so far
  logic                 rd_ff;               // Read direction
  logic                 hi_ff;               // Next read byte is high
  logic [7:0]           cmd_ff;              // Selected command
  logic [7:0]           lo_ff;               // Held low data byte
  logic                 oe_ff;               // Drive data low

  // Received byte including the bit sampled last
  wire [7:0] rx_byte = sh_ff;
  wire addr_hit = (rx_byte[7:1] == DEV_ADDR);

  // Byte commands commit on the first data byte, words on the second
  wire is_byte_cmd = (cmd_ff == fls_pkg::CMD_OT_REACT);
  wire wr_byte = (bs_ff == fls_pkg::BS_RX) & scl_fall & (cnt_ff == 4'h8)
               & ~rd_ff & (nbyte_ff == 2'h2) & is_byte_cmd;
  wire wr_word = (bs_ff == fls_pkg::BS_RX) & scl_fall & (cnt_ff == 4'h8)
               & ~rd_ff & (nbyte_ff == 2'h3) & ~hi_ff & ~is_byte_cmd;

  // Read data selection; unknown commands answer zero
  logic [15:0] rd_word;
  assign rd_word =
    (cmd_ff == fls_pkg::CMD_UC_PEAK_THR) ? uc_peak_thr_ff  :
    (cmd_ff == fls_pkg::CMD_OT_FLT_THR)  ? ot_fault_thr_ff :
    (cmd_ff == fls_pkg::CMD_OT_REACT)    ? {8'h00, ot_react_ff} :
    (cmd_ff == fls_pkg::CMD_OT_WARN_THR) ? ot_warn_thr_ff  :
    (cmd_ff == fls_pkg::CMD_UT_WARN_THR) ? ut_warn_thr_ff  :
    16'h0000;
  wire [7:0] rd_byte = hi_ff ? rd_word[15:8] : rd_word[7:0];

  // ----------------------------------------------------------------
  // Bus engine; acts on settled clock edges and on start and stop conditions
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bs_ff    <= fls_pkg::BS_IDLE;
      cnt_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      tx_ff    <= 8'h00;
      nbyte_ff <= 2'h0;
      rd_ff    <= 1'b0;
      hi_ff    <= 1'b0;
      cmd_ff   <= 8'h00;
      lo_ff    <= 8'h00;
      oe_ff    <= 1'b0;
    end else if (start_c) begin
      // Start or repeated start keeps the selected command
      bs_ff    <= fls_pkg::BS_RX;
      cnt_ff   <= 4'h0;
      nbyte_ff <= 2'h0;
      rd_ff    <= 1'b0;
      hi_ff    <= 1'b0;
      oe_ff    <= 1'b0;
    end else if (stop_c) begin
      bs_ff <= fls_pkg::BS_IDLE;
      oe_ff <= 1'b0;
    end else begin
      unique case (bs_ff)
        fls_pkg::BS_IDLE: oe_ff <= 1'b0;
        fls_pkg::BS_RX: begin
          if (scl_rise) begin
            sh_ff  <= {sh_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == 4'h8) begin
            cnt_ff   <= 4'h0;
            nbyte_ff <= (nbyte_ff == 2'h3) ? 2'h3 : nbyte_ff + 2'h1;
            if (nbyte_ff == 2'h0) begin
              // Address byte: acknowledge only our own
              if (addr_hit) begin
                rd_ff <= rx_byte[0];
                oe_ff <= 1'b1;
                bs_ff <= fls_pkg::BS_ACK;
              end else begin
                bs_ff <= fls_pkg::BS_IDLE;
              end
            end else begin
              if (nbyte_ff == 2'h1) begin
                cmd_ff <= rx_byte;
              end
              if (nbyte_ff == 2'h2) begin
                lo_ff <= rx_byte;
              end
              // Word done; later bytes are acknowledged but dropped
              if (nbyte_ff == 2'h3 && !rd_ff) begin
                hi_ff <= 1'b1;
              end
              oe_ff <= 1'b1;
              bs_ff <= fls_pkg::BS_ACK;
            end
          end
        end
        fls_pkg::BS_ACK: begin
          if (scl_fall) begin
            if (rd_ff) begin
              // First data bit goes out on the same falling edge
              tx_ff  <= rd_byte;
              oe_ff  <= ~rd_byte[7];
              cnt_ff <= 4'h1;
              bs_ff  <= fls_pkg::BS_TX;
            end else begin
              oe_ff <= 1'b0;
              bs_ff <= fls_pkg::BS_RX;
            end
          end
        end
        fls_pkg::BS_TX: begin
          if (scl_fall) begin
            if (cnt_ff == 4'h8) begin
              oe_ff <= 1'b0;
              hi_ff <= ~hi_ff;
              bs_ff <= fls_pkg::BS_RACK;
            end else begin
              oe_ff  <= ~tx_ff[3'h7 - cnt_ff[2:0]];
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        fls_pkg::BS_RACK: begin
          if (scl_rise && sda_s) begin
            // Host NACK ends the read
            bs_ff <= fls_pkg::BS_IDLE;
          end else if (scl_fall) begin
            tx_ff  <= rd_byte;
            oe_ff  <= ~rd_byte[7];
            cnt_ff <= 4'h1;
            bs_ff  <= fls_pkg::BS_TX;
          end
        end
        default: bs_ff <= fls_pkg::BS_IDLE;
      endcase
    end
  end

  // Open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_ff;

  // ----------------------------------------------------------------
  // Limit register writes
  // ----------------------------------------------------------------
  wire [15:0] wdata = {rx_byte, lo_ff};   // Low byte first on the wire

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      uc_peak_thr_ff  <= fls_pkg::RST_THR;
      ot_fault_thr_ff <= fls_pkg::RST_THR;
      ot_react_ff     <= fls_pkg::RST_REACT;
      ot_warn_thr_ff  <= fls_pkg::RST_THR;
      ut_warn_thr_ff  <= fls_pkg::RST_THR;
    end else begin
      if (wr_byte) begin
        ot_react_ff <= rx_byte;
      end
      if (wr_word && cmd_ff == fls_pkg::CMD_UC_PEAK_THR) begin
        uc_peak_thr_ff <= wdata;
      end
      if (wr_word && cmd_ff == fls_pkg::CMD_OT_FLT_THR) begin
        ot_fault_thr_ff <= wdata;
      end
      if (wr_word && cmd_ff == fls_pkg::CMD_OT_WARN_THR) begin
        ot_warn_thr_ff <= wdata;
      end
      if (wr_word && cmd_ff == fls_pkg::CMD_UT_WARN_THR) begin
        ut_warn_thr_ff <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Limit compares
  // ----------------------------------------------------------------
  wire signed [47:0] t_fx  = lin_fx(temp_lin);
  wire signed [47:0] uc_fx = lin_fx(uc_peak_thr_ff);
  wire uc_hit = (lin_fx(iph0_lin) < uc_fx) | (lin_fx(iph1_lin) < uc_fx);
  wire ot_hit = (t_fx > lin_fx(ot_fault_thr_ff));
  wire ow_hit = (t_fx > lin_fx(ot_warn_thr_ff));
  wire uw_hit = (t_fx < lin_fx(ut_warn_thr_ff));

  // Doubling in Linear is one step of exponent; mantissa kept
  assign uc_combined_lim = {uc_peak_thr_ff[15:11] + 5'h01,
                            uc_peak_thr_ff[10:0]};

  // ----------------------------------------------------------------
  // Sticky status; a new event wins over a clear
  // ----------------------------------------------------------------
  fls_pkg::fls_status_t st_ff, hit;
  logic                 ot_d_ff;              // Previous fault compare

  assign hit = '{ot_fault: ot_hit, uc_fault: uc_hit,
                 ot_warn: ow_hit, ut_warn: uw_hit};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff   <= '0;
      ot_d_ff <= 1'b0;
    end else begin
      st_ff   <= hit | (clear_faults ? '0 : st_ff);
      ot_d_ff <= ot_hit;
    end
  end

  assign status      = st_ff;
  // Alert follows any latched bit, whatever reaction mode is set
  assign alert_out_n = ~(|st_ff);

  // ----------------------------------------------------------------
  // Reaction sequencer; warnings never reach it
  // ----------------------------------------------------------------
  wire ot_trig = ot_hit & ~ot_d_ff;

  fls_retry #(
    .STEP_CYC (STEP_CYC)
  ) u_retry (
    .clk        (clk),
    .resetn     (resetn),
    .fault_trig (ot_trig),
    .resp       (ot_react_ff),
    .on_req     (on_req),
    .clear      (clear_faults),
    .out_en     (out_en)
  );

endmodule : fls_top

//--- fls_pkg.sv
// Shared constants and carrier types of the fault limit and retry supervisor.
// Assumes a 100 MHz core clock and a two-wire management bus on pins.
package fls_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UC_PEAK_THR = 8'h4B;  // Under-current peak, word
  localparam logic [7:0] CMD_OT_FLT_THR  = 8'h4F;  // Over-temp fault, word
  localparam logic [7:0] CMD_OT_REACT    = 8'h50;  // Over-temp reaction, byte
  localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;  // Over-temp warning, word
  localparam logic [7:0] CMD_UT_WARN_THR = 8'h52;  // Under-temp warning, word

  // ----------------------------------------------------------------
  // Reset values (none given, neutral zero)
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_THR   = 16'h0000;
  localparam logic [7:0]  RST_REACT = 8'h00;

  // ----------------------------------------------------------------
  // Reaction byte layout
  // ----------------------------------------------------------------
  localparam int RESP_MODE_LSB  = 6;              // Bits 7:6
  localparam int RESP_RETRY_LSB = 3;              // Bits 5:3
  localparam int RESP_TIME_LSB  = 0;              // Bits 2:0
  localparam logic [1:0] MODE_RETRY    = 2'h2;    // Disable and retry
  localparam logic [1:0] MODE_SHUTDOWN = 2'h3;    // Disable until cleared
  localparam logic [2:0] RETRY_NONE    = 3'h0;    // No restart
  localparam logic [2:0] RETRY_ALWAYS  = 3'h7;    // Restart without limit

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint RETRY_STEP_MS = 35;          // One retry time step
  localparam longint RETRY_STEP_CYC_L = (RETRY_STEP_MS * CLK_HZ) / 64'd1000;
  localparam logic [31:0] RETRY_STEP_CYC = RETRY_STEP_CYC_L[31:0];

  // ----------------------------------------------------------------
  // Bus address (arbitrary default)
  // ----------------------------------------------------------------
  localparam logic [6:0] BUS_ADDR = 7'h2A;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;     // Interruption mode
    logic [2:0] retries;  // Restart attempts
    logic [2:0] rtime;    // Delay code, (code+1) steps
  } fls_resp_t;

  typedef struct packed {
    logic ot_fault;       // Over-temperature fault
    logic uc_fault;       // Under-current fault
    logic ot_warn;        // Over-temperature warning
    logic ut_warn;        // Under-temperature warning
  } fls_status_t;

  typedef enum logic [1:0] {
    RS_RUN   = 2'h0,      // Output allowed
    RS_WAIT  = 2'h1,      // Off, counting retry delay
    RS_LATCH = 2'h3       // Off until cleared
  } fls_rstate_t;

  typedef enum logic [2:0] {
    BS_IDLE = 3'h0,       // Not addressed
    BS_RX   = 3'h1,       // Shifting in a byte
    BS_ACK  = 3'h3,       // Driving acknowledge
    BS_TX   = 3'h2,       // Shifting out a byte
    BS_RACK = 3'h6        // Sampling host acknowledge
  } fls_bstate_t;

endpackage : fls_pkg

//--- fls_retry.sv
// Fault reaction sequencer: shutdown, retry delay and retry counting.
// Assumes fault_trig is a one-cycle pulse on the core clock.
`timescale 1ns/10ps
module fls_retry #(
  parameter logic [31:0] STEP_CYC = fls_pkg::RETRY_STEP_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              fault_trig,
  input  wire fls_pkg::fls_resp_t resp,
  input  wire logic              on_req,
  input  wire logic              clear,
  output logic                   out_en
);

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  fls_pkg::fls_rstate_t st_ff, nxt_st;   // Sequencer state
  logic [31:0] step_ff, nxt_step;        // Cycles left in step
  logic [2:0]  slot_ff, nxt_slot;        // Steps left in delay
  logic [2:0]  used_ff, nxt_used;        // Restarts made so far

  wire is_retry = (resp.mode == fls_pkg::MODE_RETRY);
  wire is_shut  = (resp.mode == fls_pkg::MODE_SHUTDOWN);
  wire no_retry = (resp.retries == fls_pkg::RETRY_NONE);
  wire forever_ = (resp.retries == fls_pkg::RETRY_ALWAYS);
  wire spent    = ~forever_ & (used_ff == resp.retries);
  wire delay_done = (step_ff == 32'h0000_0000) & (slot_ff == 3'h0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    nxt_step = step_ff;
    nxt_slot = slot_ff;
    nxt_used = used_ff;
    if (!on_req) begin
      // Disabled output ends any retry run
      nxt_st   = fls_pkg::RS_RUN;
      nxt_used = 3'h0;
    end else begin
      unique case (st_ff)
        fls_pkg::RS_RUN: begin
          if (clear) begin
            nxt_used = 3'h0;
          end
          if (fault_trig && is_retry) begin
            if (no_retry || spent) begin
              nxt_st = fls_pkg::RS_LATCH;
            end else begin
              // Off at once, delay of (code+1) steps
              nxt_st   = fls_pkg::RS_WAIT;
              nxt_step = STEP_CYC - 32'h0000_0001;
              nxt_slot = resp.rtime;
            end
          end else if (fault_trig && is_shut) begin
            nxt_st = fls_pkg::RS_LATCH;
          end
        end
        fls_pkg::RS_WAIT: begin
          if (delay_done) begin
            nxt_st = fls_pkg::RS_RUN;
            // Count limited runs only; unlimited mode never reads it
            if (!forever_) begin
              nxt_used = used_ff + 3'h1;
            end
          end else if (step_ff == 32'h0000_0000) begin
            nxt_step = STEP_CYC - 32'h0000_0001;
            nxt_slot = slot_ff - 3'h1;
          end else begin
            nxt_step = step_ff - 32'h0000_0001;
          end
        end
        fls_pkg::RS_LATCH: begin
          if (clear) begin
            nxt_st   = fls_pkg::RS_RUN;
            nxt_used = 3'h0;
          end
        end
        default: nxt_st = fls_pkg::RS_LATCH;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff   <= fls_pkg::RS_RUN;
      step_ff <= 32'h0000_0000;
      slot_ff <= 3'h0;
      used_ff <= 3'h0;
    end else begin
      st_ff   <= nxt_st;
      step_ff <= nxt_step;
      slot_ff <= nxt_slot;
      used_ff <= nxt_used;
    end
  end

  // Output drops in the same cycle the state leaves run
  assign out_en = on_req & (st_ff == fls_pkg::RS_RUN);

endmodule : fls_retry

//--- fls_host.sv
// Host model of the two-wire management bus: frames, bytes, transfers.
// Assumes the bench builds an open-drain SDA wire with a pull-up.
`timescale 1ns/10ps
module fls_host (
  output logic      scl,
  output logic      sdo,
  input  wire logic sda
);
  logic nak;  // Last acknowledge slot read high
  initial begin
    scl = 1'b1;
    sdo = 1'b1;
    nak = 1'b0;
  end
  // One 80 ns bit; a one releases SDA so the device may drive it
  task automatic bt(input logic b, output logic q);
    sdo = b;
    #20 scl = 1'b1;
    #20 q = sda;
    #20 scl = 1'b0;
    #20;
  endtask : bt
  // Start or repeated start; SCL stands high between frames
  task automatic st();
    sdo = 1'b1;
    #20 scl = 1'b1;
    #20 sdo = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask : st
  task automatic sp();
    sdo = 1'b0;
    #20 scl = 1'b1;
    #20 sdo = 1'b1;
    #40;
  endtask : sp
  // Byte out (all ones to read in), then the acknowledge slot
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], q[i]);
    end
    bt(a, nak);
  endtask : xb
  task automatic wr(input logic [6:0] ad, input logic [7:0] c, input logic [15:0] v,
                    input logic w);
    logic [7:0] q;
    st();
    xb({ad, 1'b0}, 1'b1, q);
    if (!nak) begin
      xb(c, 1'b1, q);
      xb(v[7:0], 1'b1, q);
      if (w) xb(v[15:8], 1'b1, q);
    end
    sp();
  endtask : wr
  task automatic rd(input logic [6:0] ad, input logic [7:0] c, output logic [15:0] v);
    logic [7:0] q;
    st();
    xb({ad, 1'b0}, 1'b1, q);
    xb(c, 1'b1, q);
    st();
    xb({ad, 1'b1}, 1'b1, q);
    xb(8'hFF, 1'b0, v[7:0]);
    xb(8'hFF, 1'b1, v[15:8]);
    sp();
  endtask : rd
endmodule : fls_host

//--- fls_checker.sv
// Checker of alert, fault and retry timing at the supervisor pins.
// Bound into fls_top; sees its ports only.
`timescale 1ns/10ps
module fls_checker #(
  parameter logic [31:0] STEP_CYC = 32'h14
) (
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                scl_in,
  input wire logic                sda_oe,
  input wire logic [15:0]         iph0_lin,
  input wire logic [15:0]         iph1_lin,
  input wire logic                on_req,
  input wire logic                clear_faults,
  input wire logic                out_en,
  input wire fls_pkg::fls_status_t status,
  input wire logic                alert_out_n,
  input wire logic [15:0]         uc_combined_lim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [31:0] low_ff;  // Cycles held off while enabled
  logic        clr_ff;  // Off time ended by clear, not by a retry
  wire  [4:0]  lim_e = uc_combined_lim[15:11] - 5'h01;
  wire lo0 = iph0_lin[15:11] == lim_e && $signed(iph0_lin[10:0]) < $signed(uc_combined_lim[10:0]);
  wire lo1 = iph1_lin[15:11] == lim_e && $signed(iph1_lin[10:0]) < $signed(uc_combined_lim[10:0]);
  // Off-time counter for the retry spacing check
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_ff <= 32'h0;
      clr_ff <= 1'b0;
    end else begin
      low_ff <= (out_en || !on_req) ? 32'h0 : low_ff + 32'h1;
      clr_ff <= clear_faults || (clr_ff && !out_en);
    end
  end
  a_alert_status: assert property (alert_out_n == (4'(status) == 4'h0))
    else $error("alert does not follow status");
  a_status_sticky: assert property (!clear_faults |=> (4'($past(status)) & ~4'(status)) == 4'h0)
    else $error("status bit lost without clear");
  a_uc_phase0: assert property (lo0 |=> status.uc_fault)
    else $error("phase 0 under-current missed");
  a_uc_phase1: assert property (lo1 |=> status.uc_fault)
    else $error("phase 1 under-current missed");
  a_off_cause: assert property ($fell(out_en) && on_req && $past(on_req) |-> status.ot_fault)
    else $error("output off without fault");
  a_off_disabled: assert property (!on_req |-> !out_en)
    else $error("output on while disabled");
  a_retry_space: assert property ($rose(out_en) && $past(on_req) && !clr_ff |->
    low_ff >= STEP_CYC && low_ff <= (STEP_CYC << 3) + 32'h2) else $error("retry delay off");
  a_warn_keeps: assert property ($rose(status.ot_warn) && $past(out_en) && on_req
    && !status.ot_fault |-> out_en) else $error("warning shut output");
  a_bus_hold: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed with clock high");
  c_fault: cover property ($rose(status.ot_fault));
  c_retry: cover property ($rose(out_en) && $past(on_req) && !clr_ff);
  c_drive: cover property ($rose(sda_oe));
endmodule : fls_checker

bind fls_top fls_checker #(.STEP_CYC(STEP_CYC)) chk_u (.clk(clk), .resetn(resetn),
  .scl_in(scl_in), .sda_oe(sda_oe), .iph0_lin(iph0_lin), .iph1_lin(iph1_lin),
  .on_req(on_req), .clear_faults(clear_faults), .out_en(out_en), .status(status),
  .alert_out_n(alert_out_n), .uc_combined_lim(uc_combined_lim));

//--- tb.sv
// Bench of the supervisor: bus host, limits, faults and retries.
// Retry step shortened to 20 clocks; bus bit time 80 ns.
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] STP = 32'h14;
  localparam logic [6:0]  AD  = fls_pkg::BUS_ADDR;
  logic clk, resetn, on_req, clear_faults, sda_out, sda_oe, out_en, alert_out_n;
  logic [15:0] temp_lin, iph0_lin, iph1_lin, uc_combined_lim, v, r, m;
  fls_pkg::fls_status_t status;
  wire scl, sdo;
  wire sda = sdo & (sda_oe ? sda_out : 1'b1);  // Open drain with pull-up
  int n_errors, checks, cyc, n, e, mdl [int];
  logic [7:0] cm [5] = '{8'h4B, 8'h4F, 8'h50, 8'h51, 8'h52};
  logic [7:0] rx [6] = '{8'h00, 8'h41, 8'hC0, 8'h80, 8'h8A, 8'hB8};
  fls_host host_u (.scl(scl), .sdo(sdo), .sda(sda));
  fls_top #(.STEP_CYC(STP)) dut_u (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .temp_lin(temp_lin), .iph0_lin(iph0_lin),
    .iph1_lin(iph1_lin), .on_req(on_req), .clear_faults(clear_faults), .out_en(out_en),
    .status(status), .alert_out_n(alert_out_n), .uc_combined_lim(uc_combined_lim));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task finish_test();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Step past edges; inputs then change just after the edge
  task tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tk
  task clr();
    clear_faults <= 1'b1;
    tk(1);
    clear_faults <= 1'b0;
    tk(2);
  endtask : clr
  // Fault pulses under one reaction byte; off time measured
  task fault(input logic [7:0] re);
    host_u.wr(AD, 8'h50, {8'h00, re}, 1'b0);
    clr();
    for (int k = 0; k <= (re[5:3] == 3'h7 ? 2 : int'(re[5:3])); k++) begin
      temp_lin <= 16'h0070;
      tk(1);
      temp_lin <= 16'h0020;
      tk(3);
      chk({alert_out_n, status.ot_fault}, 16'h0001);
      n = 0;
      while (!out_en && n < 200) begin
        tk(1);
        n++;
      end
      e = re[7:6] < 2'h2 ? 0 : (re[7:6] == 2'h2 && (re[5:3] == 3'h7 || k < re[5:3])) ?
          int'((re[2:0] + 1) * STP) - 2 : 200;
      chk(16'(n > e + 1 || n + 2 < e), 16'h0000);
    end
    clr();
    chk(out_en, 1'b1);
  endtask : fault
  initial begin
    resetn = 1'b0;
    on_req = 1'b0;
    clear_faults = 1'b0;
    temp_lin = 16'h0020;
    iph0_lin = 16'h0064;
    iph1_lin = 16'h0064;
    void'($urandom(32'hD040));
    tk(8);
    resetn <= 1'b1;
    on_req <= 1'b1;
    tk(4);
    foreach (cm[i]) begin
      m = cm[i] == 8'h50 ? 16'h00FF : 16'hFFFF;
      host_u.rd(AD, cm[i], r);
      chk(r & m, 16'h0000);
      v = 16'($urandom_range(1023, 0)) & m;
      mdl[cm[i]] = v;
      host_u.wr(AD, cm[i], v, m[8]);
      host_u.rd(AD, cm[i], r);
      chk(r & m, 16'(mdl[cm[i]]));
    end
    host_u.wr(AD + 7'h01, 8'h4F, 16'h0000, 1'b1);
    chk(host_u.nak, 1'b1);
    host_u.wr(AD, 8'h4B, 16'h0050, 1'b1);
    host_u.wr(AD, 8'h4F, 16'h0060, 1'b1);
    host_u.wr(AD, 8'h51, 16'h0030, 1'b1);
    host_u.wr(AD, 8'h52, 16'h0010, 1'b1);
    chk(uc_combined_lim, 16'h0850);
    clr();
    for (int p = 0; p < 2; p++) begin
      if (p == 0) iph0_lin <= 16'h004F;
      else iph1_lin <= 16'h004F;
      tk(3);
      chk({alert_out_n, out_en, 4'(status)}, 16'h0014);
      iph0_lin <= 16'h0050;
      iph1_lin <= 16'h0050;
      clr();
      chk(4'(status), 16'h0000);
    end
    temp_lin <= 16'h0031;
    tk(3);
    chk({out_en, 4'(status)}, 16'h0012);
    temp_lin <= 16'h000F;
    tk(3);
    chk({out_en, 4'(status)}, 16'h0013);
    temp_lin <= 16'h0020;
    rx[5][2:0] = 3'($urandom_range(7, 0));
    foreach (rx[i]) fault(rx[i]);
    on_req <= 1'b0;
    tk(2);
    chk(out_en, 1'b0);
    finish_test();
  end
endmodule : tb
